// File: hw/llac_pkg.sv
// Constants and types shared by the loopback and alarm control block
package llac_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC_DEF  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned QUAL_TIME_S   = 5;
  localparam int unsigned QUAL_TICK_DEF = QUAL_TIME_S * 1_000_000 / TICK_US;
  localparam int unsigned TICK_W        = 18;
  localparam int unsigned QUAL_W        = 13;

  // Pattern window: one T1 frame of bits
  localparam logic [7:0] FRAME_BITS = 8'hC1;
  localparam logic [3:0] MISS_MAX   = 4'h4;
  localparam logic [3:0] MISS_SAT   = 4'hF;
  localparam logic [7:0] ONES5_LO   = 8'h24;
  localparam logic [7:0] ONES5_HI   = 8'h2A;
  localparam logic [7:0] ONES3_LO   = 8'h3E;
  localparam logic [7:0] ONES3_HI   = 8'h43;
  localparam int unsigned PER5      = 5;
  localparam int unsigned PER3      = 3;

  // Side indices
  localparam int unsigned SIDE_LINE = 0;
  localparam int unsigned SIDE_CPE  = 1;

  // Register map
  localparam int unsigned AW         = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATE   = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_IRQ_EN  = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [1:0] CTRL_RST    = 2'h3;
  localparam int unsigned EV_W       = 6;

  // Status bit positions
  localparam int unsigned EV_LINE_ON  = 0;
  localparam int unsigned EV_LINE_OFF = 1;
  localparam int unsigned EV_CPE_ON   = 2;
  localparam int unsigned EV_CPE_OFF  = 3;
  localparam int unsigned EV_LINE_LOS = 4;
  localparam int unsigned EV_CPE_LOS  = 5;

  typedef enum logic {
    LLAC_OPEN   = 1'b0,
    LLAC_LOOPED = 1'b1
  } llac_loop_e;

  typedef struct packed {
    logic [4:0]        hist;
    logic [7:0]        bitCnt;
    logic [7:0]        ones;
    logic [3:0]        miss5;
    logic [3:0]        miss3;
    logic              run5;
    logic              run3;
    logic [QUAL_W-1:0] qual5;
    logic [QUAL_W-1:0] qual3;
    llac_loop_e        loop;
  } llac_side_s;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
  } llac_bus_s;

  typedef struct packed {
    logic syncLamp;
    logic lineSignalLossLamp;
    logic cpeSignalLossLamp;
    logic lineManualLoopLamp;
    logic lineRemoteLoopLamp;
    logic cpeManualLoopLamp;
    logic cpeRemoteLoopLamp;
  } llac_lamp_s;
endpackage

// File: hw/llac_line_loop.sv
// Loopback, pattern detection and alarm lamp control between line and CPE
`timescale 1ns/1ps
// Operation
// - Line loop: line data back to line, all ones to CPE, CPE input ignored
// - Line switch on with CPE switch off holds manual line loop and lights its lamp
// - Five seconds of one-in-five from line closes remote line loop, lamp on
// - Five seconds of one-in-three from same side opens remote loop, lamp off
// - Pattern detectors work unframed or inside SF and ESF framing
// - CPE loop: CPE data back to CPE, all ones to line, line input ignored
// - CPE switch on with line switch off lights its lamp and holds manual CPE loop unless the line loop is closed
// - Five seconds of one-in-five from CPE closes remote CPE loop, lamp on
// - Position 6 up, 7 down is line loop; 6 down, 7 up is CPE loop
// - Sync lamp only while both sides carry signal
// - Line loss lamp while line signal is lost
// - CPE loss lamp while CPE signal is lost
// - Outside loops, data passes unaltered in both directions
module llac_line_loop #(
  parameter int unsigned TickCycles = llac_pkg::TICK_CYC_DEF,
  parameter int unsigned QualTicks  = llac_pkg::QUAL_TICK_DEF
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               lineRxBit,
  input  wire logic               lineRxEn,
  input  wire logic               cpeRxBit,
  input  wire logic               cpeRxEn,
  input  wire logic               lineSignalOk,
  input  wire logic               cpeSignalOk,
  input  wire logic               lineLoopSwitch,
  input  wire logic               cpeLoopSwitch,
  output logic                    lineTxBit,
  output logic                    lineTxEn,
  output logic                    cpeTxBit,
  output logic                    cpeTxEn,
  output llac_pkg::llac_lamp_s    lamps,
  input  wire logic [llac_pkg::AW-1:0] regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic [31:0]             regRdata,
  output logic                    irq
);
  import llac_pkg::*;

  typedef struct packed {
    llac_side_s [1:0]  side;
    logic [TICK_W-1:0] tickCnt;
    logic [1:0]        ctrl;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   irqEn;
    logic [1:0]        losPrev;
    logic              lineTxBit;
    logic              lineTxEn;
    logic              cpeTxBit;
    logic              cpeTxEn;
    llac_lamp_s        lamps;
    logic [31:0]       rdata;
    logic              irq;
  } llac_state_s;

  llac_state_s st_r;
  llac_state_s st_nxt;

  llac_bus_s bus;
  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  logic [1:0] rxBit;
  logic [1:0] rxEn;
  assign rxBit = {cpeRxBit, lineRxBit};
  assign rxEn  = {cpeRxEn, lineRxEn};

  always_comb begin
    logic             tick;
    logic             b;
    logic             m5;
    logic             m3;
    logic [3:0]       mi5;
    logic [3:0]       mi3;
    logic [7:0]       on;
    logic             pass5;
    logic             pass3;
    logic             lineMan;
    logic             cpeMan;
    logic             lineLoop;
    logic             cpeLoop;
    logic [EV_W-1:0]  ev;
    logic [1:0]       los;
    logic [1:0]       bitIn;
    tick     = 1'b0;
    b        = 1'b0;
    m5       = 1'b0;
    m3       = 1'b0;
    mi5      = '0;
    mi3      = '0;
    on       = '0;
    pass5    = 1'b0;
    pass3    = 1'b0;
    ev       = '0;
    lineMan  = 1'b0;
    cpeMan   = 1'b0;
    lineLoop = 1'b0;
    cpeLoop  = 1'b0;
    los      = '0;
    bitIn    = rxBit;
    st_nxt   = st_r;

    // Millisecond enable for the qualification timers
    if (st_r.tickCnt == TICK_W'(TickCycles - 1)) begin
      st_nxt.tickCnt = '0;
      tick           = 1'b1;
    end else begin
      st_nxt.tickCnt = st_r.tickCnt + 1'b1;
    end

    for (int i = 0; i < 2; i++) begin
      if (rxEn[i]) begin
        b   = bitIn[i];
        m5  = b != st_r.side[i].hist[PER5-1];
        m3  = b != st_r.side[i].hist[PER3-1];
        mi5 = (st_r.side[i].miss5 == MISS_SAT) ? MISS_SAT : st_r.side[i].miss5 + 4'(m5);
        mi3 = (st_r.side[i].miss3 == MISS_SAT) ? MISS_SAT : st_r.side[i].miss3 + 4'(m3);
        on  = st_r.side[i].ones + 8'(b);
        st_nxt.side[i].hist = {st_r.side[i].hist[3:0], b};
        st_nxt.side[i].miss5 = mi5;
        st_nxt.side[i].miss3 = mi3;
        st_nxt.side[i].ones  = on;
        // Framing bits cost a few mismatches per frame; tolerate them
        if (st_r.side[i].bitCnt == FRAME_BITS - 8'h01) begin
          pass5 = mi5 <= MISS_MAX && on >= ONES5_LO && on <= ONES5_HI;
          pass3 = mi3 <= MISS_MAX && on >= ONES3_LO && on <= ONES3_HI;
          st_nxt.side[i].run5   = pass5;
          st_nxt.side[i].run3   = pass3;
          st_nxt.side[i].bitCnt = '0;
          st_nxt.side[i].miss5  = '0;
          st_nxt.side[i].miss3  = '0;
          st_nxt.side[i].ones   = '0;
          if (!pass5) st_nxt.side[i].qual5 = '0;
          if (!pass3) st_nxt.side[i].qual3 = '0;
        end else begin
          st_nxt.side[i].bitCnt = st_r.side[i].bitCnt + 8'h01;
          if (mi5 > MISS_MAX) begin
            st_nxt.side[i].run5  = 1'b0;
            st_nxt.side[i].qual5 = '0;
          end
          if (mi3 > MISS_MAX) begin
            st_nxt.side[i].run3  = 1'b0;
            st_nxt.side[i].qual3 = '0;
          end
        end
      end
      if (tick && st_nxt.side[i].run5 && st_r.side[i].qual5 != QUAL_W'(QualTicks)) begin
        st_nxt.side[i].qual5 = st_r.side[i].qual5 + 1'b1;
      end
      if (tick && st_nxt.side[i].run3 && st_r.side[i].qual3 != QUAL_W'(QualTicks)) begin
        st_nxt.side[i].qual3 = st_r.side[i].qual3 + 1'b1;
      end
      unique case (st_r.side[i].loop)
        LLAC_OPEN: begin
          if (st_r.side[i].qual5 == QUAL_W'(QualTicks) && st_r.ctrl[i]) begin
            st_nxt.side[i].loop  = LLAC_LOOPED;
            st_nxt.side[i].qual3 = '0;
            ev[2*i]              = 1'b1;
          end
        end
        LLAC_LOOPED: begin
          if (st_r.side[i].qual3 == QUAL_W'(QualTicks) || !st_r.ctrl[i]) begin
            st_nxt.side[i].loop  = LLAC_OPEN;
            st_nxt.side[i].qual5 = '0;
            ev[2*i+1]            = 1'b1;
          end
        end
      endcase
    end

    lineMan  = lineLoopSwitch && !cpeLoopSwitch;
    cpeMan   = cpeLoopSwitch && !lineLoopSwitch;
    lineLoop = lineMan || st_r.side[SIDE_LINE].loop == LLAC_LOOPED;
    cpeLoop  = !lineLoop && (cpeMan || st_r.side[SIDE_CPE].loop == LLAC_LOOPED);

    // Data path, paced by the strobe of the side the bit comes from
    if (lineLoop) begin
      st_nxt.lineTxBit = lineRxBit;
      st_nxt.lineTxEn  = lineRxEn;
      st_nxt.cpeTxBit  = 1'b1;
      st_nxt.cpeTxEn   = lineRxEn;
    end else if (cpeLoop) begin
      st_nxt.cpeTxBit  = cpeRxBit;
      st_nxt.cpeTxEn   = cpeRxEn;
      st_nxt.lineTxBit = 1'b1;
      st_nxt.lineTxEn  = cpeRxEn;
    end else begin
      st_nxt.lineTxBit = cpeRxBit;
      st_nxt.lineTxEn  = cpeRxEn;
      st_nxt.cpeTxBit  = lineRxBit;
      st_nxt.cpeTxEn   = lineRxEn;
    end

    los = {!cpeSignalOk, !lineSignalOk};
    st_nxt.losPrev = los;
    ev[EV_LINE_LOS] = los[SIDE_LINE] && !st_r.losPrev[SIDE_LINE];
    ev[EV_CPE_LOS]  = los[SIDE_CPE] && !st_r.losPrev[SIDE_CPE];

    st_nxt.lamps.syncLamp           = lineSignalOk && cpeSignalOk;
    st_nxt.lamps.lineSignalLossLamp = los[SIDE_LINE];
    st_nxt.lamps.cpeSignalLossLamp  = los[SIDE_CPE];
    st_nxt.lamps.lineManualLoopLamp = lineMan;
    st_nxt.lamps.cpeManualLoopLamp  = cpeMan;
    st_nxt.lamps.lineRemoteLoopLamp = st_nxt.side[SIDE_LINE].loop == LLAC_LOOPED;
    st_nxt.lamps.cpeRemoteLoopLamp  = st_nxt.side[SIDE_CPE].loop == LLAC_LOOPED;

    // Register writes; a new event wins over its clear
    if (bus.wr) begin
      unique case (bus.addr)
        REG_CTRL:    st_nxt.ctrl   = bus.wdata[1:0];
        REG_IRQ_EN:  st_nxt.irqEn  = bus.wdata[EV_W-1:0];
        REG_IRQ_CLR: st_nxt.status = st_r.status & ~bus.wdata[EV_W-1:0];
        default: ;
      endcase
    end
    st_nxt.status = st_nxt.status | ev;

    st_nxt.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        REG_CTRL:   st_nxt.rdata = 32'(st_r.ctrl);
        REG_STATE:  st_nxt.rdata = 32'(st_r.lamps);
        REG_STATUS: st_nxt.rdata = 32'(st_r.status);
        REG_IRQ_EN: st_nxt.rdata = 32'(st_r.irqEn);
        default:    st_nxt.rdata = '0;
      endcase
    end
    st_nxt.irq = |(st_nxt.status & st_nxt.irqEn);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lineTxBit = st_r.lineTxBit;
  assign lineTxEn  = st_r.lineTxEn;
  assign cpeTxBit  = st_r.cpeTxBit;
  assign cpeTxEn   = st_r.cpeTxEn;
  assign lamps     = st_r.lamps;
  assign regRdata  = st_r.rdata;
  assign irq       = st_r.irq;
endmodule // llac_line_loop

// File: tb/llac_properties.sv
// Checker: lamp, data path and register port properties
`timescale 1ns/1ps
module llac_properties #(
  parameter int unsigned TickCycles = 4,
  parameter int unsigned QualTicks  = 3
) (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire logic                 lineRxBit,
  input wire logic                 lineRxEn,
  input wire logic                 cpeRxBit,
  input wire logic                 cpeRxEn,
  input wire logic                 lineSignalOk,
  input wire logic                 cpeSignalOk,
  input wire logic                 lineLoopSwitch,
  input wire logic                 cpeLoopSwitch,
  input wire logic                 lineTxBit,
  input wire logic                 lineTxEn,
  input wire logic                 cpeTxBit,
  input wire logic                 cpeTxEn,
  input wire llac_pkg::llac_lamp_s lamps,
  input wire logic                 regRd,
  input wire logic [31:0]          regRdata
);
  import llac_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire quiet = !lineLoopSwitch && !cpeLoopSwitch && lamps[3:0] == 4'h0;
  // Strobe with all loops open for the whole transfer
  sequence s_open(en);
    (en && quiet) ##1 quiet ##1 quiet;
  endsequence
  AST_MAN_LINE: assert property (lineLoopSwitch && !cpeLoopSwitch |=> lamps[3])
    else $error("line manual lamp off");
  AST_MAN_CPE: assert property (cpeLoopSwitch && !lineLoopSwitch |=> lamps[1])
    else $error("cpe manual lamp off");
  AST_SYNC: assert property (!sys_rst |=> lamps[6] == $past(lineSignalOk && cpeSignalOk))
    else $error("sync lamp wrong");
  AST_LOS_LINE: assert property (!lineSignalOk |=> lamps[5])
    else $error("line loss lamp off");
  AST_LOS_CPE: assert property (cpeSignalOk |=> !lamps[4])
    else $error("cpe loss lamp on");
  AST_PASS_L2C: assert property (s_open(lineRxEn) |->
    $past(cpeTxEn) && $past(cpeTxBit) == $past(lineRxBit, 2)) else $error("line to cpe bad");
  AST_PASS_C2L: assert property (s_open(cpeRxEn) |->
    $past(lineTxEn) && $past(lineTxBit) == $past(cpeRxBit, 2)) else $error("cpe to line bad");
  AST_LOOP_LINE: assert property (lamps[3] && lineLoopSwitch && !cpeLoopSwitch && lineRxEn
    |=> cpeTxEn && cpeTxBit && lineTxEn && lineTxBit == $past(lineRxBit)) else $error("line loop bad");
  AST_LOOP_CPE: assert property (lamps[1] && !lamps[2] && cpeLoopSwitch && !lineLoopSwitch
    && cpeRxEn
    |=> lineTxEn && lineTxBit && cpeTxEn && cpeTxBit == $past(cpeRxBit)) else $error("cpe loop bad");
  AST_RD_IDLE: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data not idle");
endmodule // llac_properties
bind llac_line_loop llac_properties #(.TickCycles(TickCycles), .QualTicks(QualTicks)) u_props (
  .clock, .sys_rst, .lineRxBit, .lineRxEn, .cpeRxBit, .cpeRxEn, .lineSignalOk, .cpeSignalOk,
  .lineLoopSwitch, .cpeLoopSwitch, .lineTxBit, .lineTxEn, .cpeTxBit, .cpeTxEn, .lamps, .regRd,
  .regRdata);

// File: tb/llac_far_end.sv
// Far-end source: plain traffic, 1-in-5, 1-in-3 and framed 1-in-5
`timescale 1ns/1ps
module llac_far_end (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [1:0] mode,
  output logic            rxBit,
  output logic            rxEn
);
  logic [7:0] frm;
  logic [2:0] ph;
  logic [3:0] cnt;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {rxBit, rxEn, frm, ph, cnt} <= '0;
    end else begin
      cnt   <= cnt + 4'h1;
      rxEn  <= cnt[0];
      rxBit <= ~rxBit;  // Bit not held between strobes
      if (cnt[0]) begin
        frm <= (frm == 8'hC0) ? 8'h00 : frm + 8'h01;
        if (mode == 2'h3 && frm == 8'hC0) begin
          rxBit <= cnt[1];
        end else begin
          ph    <= (ph == ((mode == 2'h2) ? 3'h2 : 3'h4)) ? 3'h0 : ph + 3'h1;
          rxBit <= (mode == 2'h0) ? cnt[3] ^ cnt[1] : ph == 3'h0;
        end
      end
    end
  end
endmodule // llac_far_end

// File: tb/tb_llac_line_loop.sv
// Testbench for the loopback and alarm control block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", nm, e, s); end end
module tb_llac_line_loop;
  import llac_pkg::*;
  logic       clock, sys_rst, lineSignalOk, cpeSignalOk, lineLoopSwitch, cpeLoopSwitch;
  logic       lineRxBit, lineRxEn, cpeRxBit, cpeRxEn, lineTxBit, lineTxEn, cpeTxBit, cpeTxEn;
  logic       regWr, regRd, irq;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [1:0] lineMode, cpeMode;
  llac_lamp_s lamps;
  int         miscompares, samples_checked;
  llac_far_end i_line_far (.clock(clock), .sys_rst(sys_rst), .mode(lineMode), .rxBit(lineRxBit),
    .rxEn(lineRxEn));
  llac_far_end i_cpe_far (.clock(clock), .sys_rst(sys_rst), .mode(cpeMode), .rxBit(cpeRxBit),
    .rxEn(cpeRxEn));
  llac_line_loop #(.TickCycles(4), .QualTicks(3)) i_dut (.clock(clock), .sys_rst(sys_rst),
    .lineRxBit(lineRxBit), .lineRxEn(lineRxEn), .cpeRxBit(cpeRxBit), .cpeRxEn(cpeRxEn),
    .lineSignalOk(lineSignalOk), .cpeSignalOk(cpeSignalOk), .lineLoopSwitch(lineLoopSwitch),
    .cpeLoopSwitch(cpeLoopSwitch), .lineTxBit(lineTxBit), .lineTxEn(lineTxEn),
    .cpeTxBit(cpeTxBit), .cpeTxEn(cpeTxEn), .lamps(lamps), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 `CHK(nm, e, regRdata)
    @(posedge clock);
  endtask
  task automatic waitLamp(input int k, input logic v);
    int n;
    n = 0;
    while (lamps[k] !== v && n < 4000) begin
      @(posedge clock);
      #1 n++;
    end
    `CHK("lamp", v, lamps[k])
    @(posedge clock);
  endtask
  // Every strobe toward the looped-away side must carry a one
  task automatic txOnes(input logic toCpe);
    repeat (20) begin
      @(posedge clock);
      #1 if (toCpe && cpeTxEn) `CHK("cpeTx", 1'b1, cpeTxBit)
      if (!toCpe && lineTxEn) `CHK("lineTx", 1'b1, lineTxBit)
    end
    @(posedge clock);
  endtask
  task automatic sc_regs();
    rd(REG_CTRL, 32'h3, "ctrl");
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, 32'h1, "ctrl");
    wr(REG_CTRL, 32'h3);
    rd(8'hFC, 32'h0, "unmapped");
    rd(REG_STATE, 32'h40, "state");
    wr(REG_IRQ_EN, 32'h3F);
    rd(REG_IRQ_EN, 32'h3F, "irqEn");
    rd(REG_IRQ_CLR, 32'h0, "irqClr");
  endtask
  task automatic sc_pass();
    logic le, lb, ce, cb;
    {le, lb, ce, cb} = 4'h0;
    repeat (40) begin
      @(posedge clock);
      #1 if (le) `CHK("cpeTx", lb, cpeTxBit)
      if (ce) `CHK("lineTx", cb, lineTxBit)
      {le, lb, ce, cb} = {lineRxEn, lineRxBit, cpeRxEn, cpeRxBit};
    end
    @(posedge clock);
  endtask
  task automatic sc_manual();
    lineLoopSwitch <= 1'b1;
    repeat (3) @(posedge clock);
    rd(REG_STATE, 32'h48, "state");
    txOnes(1'b1);
    cpeLoopSwitch <= 1'b1;
    repeat (3) @(posedge clock);
    rd(REG_STATE, 32'h40, "state");
    lineLoopSwitch <= 1'b0;
    repeat (3) @(posedge clock);
    rd(REG_STATE, 32'h42, "state");
    txOnes(1'b0);
    cpeLoopSwitch <= 1'b0;
  endtask
  task automatic sc_remote_line();
    lineMode <= 2'h3;
    waitLamp(2, 1'b1);
    rd(REG_STATUS, 32'h1, "status");
    #1 `CHK("irq", 1'b1, irq)
    txOnes(1'b1);
    wr(REG_IRQ_CLR, 32'h1);
    #1 `CHK("irq", 1'b0, irq)
    @(posedge clock);
    wr(REG_IRQ_EN, 32'h0);
    lineMode <= 2'h2;
    waitLamp(2, 1'b0);
    #1 `CHK("irq", 1'b0, irq)
    @(posedge clock);
    rd(REG_STATUS, 32'h2, "status");
    wr(REG_IRQ_CLR, 32'h3F);
    lineMode <= 2'h0;
  endtask
  task automatic sc_remote_cpe();
    cpeMode <= 2'h1;
    repeat (300) @(posedge clock);
    cpeMode <= 2'h0;
    repeat (1000) @(posedge clock);
    rd(REG_STATE, 32'h40, "state");
    cpeMode <= 2'h1;
    waitLamp(0, 1'b1);
    txOnes(1'b0);
    cpeMode <= 2'h2;
    waitLamp(0, 1'b0);
    rd(REG_STATUS, 32'hC, "status");
    wr(REG_IRQ_CLR, 32'h3F);
    cpeMode <= 2'h0;
  endtask
  task automatic sc_los();
    lineSignalOk <= 1'b0;
    repeat (3) @(posedge clock);
    rd(REG_STATE, 32'h20, "state");
    lineSignalOk <= 1'b1;
    cpeSignalOk <= 1'b0;
    repeat (3) @(posedge clock);
    rd(REG_STATE, 32'h10, "state");
    cpeSignalOk <= 1'b1;
    rd(REG_STATUS, 32'h30, "status");
    wr(REG_IRQ_CLR, 32'h3F);
    rd(REG_STATUS, 32'h0, "status");
  endtask
  initial begin
    {sys_rst, lineSignalOk, cpeSignalOk} = 3'h7;
    {lineLoopSwitch, cpeLoopSwitch, regWr, regRd} = 4'h0;
    {regAddr, regWdata, lineMode, cpeMode} = '0;
    miscompares = 0;
    samples_checked = 0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    sc_regs();
    sc_pass();
    sc_manual();
    sc_remote_line();
    sc_remote_cpe();
    sc_los();
    results();
  end
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    results();
  end
endmodule // tb_llac_line_loop
